// File: rsu_regs.svh
// Purpose: constants of the remote image upgrade link and its controller
// Assumes: one clock per end, all counts in cycles of that clock
// Notes: offsets of the controller registers are word indices
`ifndef RSU_REGS_SVH
`define RSU_REGS_SVH

// Shift register and its fields
`define RSU_STS_W 5
`define RSU_CTL_W 38
`define RSU_SHIFT_W 43
`define RSU_CTL_ANF 0
`define RSU_CTL_ADDR_LSB 1
`define RSU_CTL_ADDR_MSB 24
`define RSU_CTL_WDEN 25
`define RSU_CTL_WDT_LSB 26
`define RSU_CTL_WDT_MSB 37
`define RSU_STS_CRC 0
`define RSU_STS_EXTERR 1
`define RSU_STS_CORE 2
`define RSU_STS_CFGPIN 3
`define RSU_STS_WDOG 4

// Reset values and fixed addresses
`define RSU_CTL_RESET 38'h00_0000_0000
`define RSU_STS_RESET 5'h00
`define RSU_FACTORY_ADDR 24'h00_0000
`define RSU_ADDR_LOW_BYTE 8'h00
`define RSU_WD_TIMEOUT_W 12
`define RSU_WD_GRAN_LOG2 17

// Controller register word indices
`define RSU_REG_CMD 3'h0
`define RSU_REG_DATA_LO 3'h1
`define RSU_REG_DATA_HI 3'h2
`define RSU_REG_IRQ_STS 3'h3
`define RSU_REG_IRQ_CLR 3'h4
`define RSU_REG_IRQ_EN 3'h5

// Command bits and interrupt bits
`define RSU_CMD_READ 0
`define RSU_CMD_WRITE 1
`define RSU_CMD_RECONF 2
`define RSU_CMD_WDRST 3
`define RSU_IRQ_W 3
`define RSU_IRQ_RD_DONE 0
`define RSU_IRQ_WR_DONE 1
`define RSU_IRQ_PULSE_DONE 2

// Timing counts in clock cycles
`define RSU_SCLK_HALF 8'd8
`define RSU_PULSE_CYC 8'd16

`endif

// File: rsu_pkg.sv
// Purpose: types shared by both ends of the upgrade link
// Assumes: constants come from rsu_regs.svh
// Notes: state codes are written out
package rsu_pkg;

  typedef enum logic [2:0] {
    RSU_DEV_LOAD_FACT = 3'b000,
    RSU_DEV_FACTORY = 3'b001,
    RSU_DEV_LOAD_APP = 3'b010,
    RSU_DEV_APP = 3'b011,
    RSU_DEV_HALT = 3'b100
  } rsu_dev_state_e;

  typedef enum logic [1:0] {
    RSU_CORE_IDLE = 2'b00,
    RSU_CORE_CAPT = 2'b01,
    RSU_CORE_SHIFT = 2'b10,
    RSU_CORE_UPDT = 2'b11
  } rsu_core_state_e;

  typedef logic [4:0] rsu_status_t;

endpackage : rsu_pkg

// File: rsu_if.sv
// Purpose: dedicated signals between core logic and upgrade circuitry
// Assumes: all signals are driven from flip-flops of one end
// Notes: no clocking block; each end synchronises what it reads
`timescale 1ns/100ps
`default_nettype none
interface rsu_if;
  logic upgrade_serial_in;
  logic upgrade_serial_out;
  logic shift_not_load_select;
  logic capture_not_update_select;
  logic upgrade_shift_clock;
  logic core_reconfig_request_n;
  logic watchdog_restart_n;

  // Upgrade circuitry end
  modport dev (
    input upgrade_serial_in, shift_not_load_select, capture_not_update_select,
    input upgrade_shift_clock, core_reconfig_request_n, watchdog_restart_n,
    output upgrade_serial_out
  );

  // Core logic end
  modport core (
    output upgrade_serial_in, shift_not_load_select, capture_not_update_select,
    output upgrade_shift_clock, core_reconfig_request_n, watchdog_restart_n,
    input upgrade_serial_out
  );
endinterface : rsu_if
`default_nettype wire

// File: rsu_sync.sv
// Purpose: two-flop synchroniser for a group of levels
// Assumes: inputs are slow against the clock
// Notes: reset value is a parameter so idle-high pins start high
`timescale 1ns/100ps
`default_nettype none
module rsu_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : rsu_sync
`default_nettype wire

// File: rsu_device.sv
// Purpose: upgrade circuitry: registers, user watchdog, load sequencer
// Assumes: ref_clk_i stands for the internal oscillator
// Notes: link pins and load pins are synchronised before use
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "rsu_regs.svh"
module rsu_device #(
  parameter int WD_GRAN_LOG2 = `RSU_WD_GRAN_LOG2
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  rsu_if.dev link,
  input wire logic remote_mode_i,
  input wire logic cfg_done_i,
  input wire logic cfg_crc_error_i,
  input wire logic ext_status_error_i,
  input wire logic ext_config_n_i,
  output logic cfg_load_o,
  output logic [31:0] cfg_addr_o,
  output logic app_mode_o,
  output logic user_mode_o,
  output logic [4:0] status_o
);
  localparam int WD_W = `RSU_WD_TIMEOUT_W + WD_GRAN_LOG2;

  // Synchronised pins: sclk, din, snl, cnu, req_n, wdr_n, and load pins
  logic [10:0] pins_s;
  logic sclk_s, din_s, snl_s, cnu_s, req_n_s, wdr_n_s;
  logic mode_s, done_s, crc_s, exterr_s, cfgpin_n_s;

  rsu_sync #(.W(11), .INIT(11'h430)) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({ext_config_n_i, ext_status_error_i, cfg_crc_error_i, cfg_done_i,
          remote_mode_i, link.watchdog_restart_n, link.core_reconfig_request_n,
          link.capture_not_update_select, link.shift_not_load_select,
          link.upgrade_serial_in, link.upgrade_shift_clock}),
    .q_o(pins_s)
  );

  assign {cfgpin_n_s, exterr_s, crc_s, done_s, mode_s, wdr_n_s, req_n_s,
          cnu_s, snl_s, din_s, sclk_s} = pins_s;

  // Previous levels for edge detection
  logic sclk_p_q, req_n_p_q, wdr_n_p_q;
  logic sclk_rise, req_fall, wdr_fall;

  assign sclk_rise = sclk_s & ~sclk_p_q;
  assign req_fall = ~req_n_s & req_n_p_q;
  assign wdr_fall = ~wdr_n_s & wdr_n_p_q;

  // Registers of the upgrade set
  rsu_pkg::rsu_dev_state_e state_q, state_d;
  logic [`RSU_SHIFT_W-1:0] shift_q, shift_d;
  logic [`RSU_CTL_W-1:0] upd_q, upd_d;
  logic [`RSU_CTL_W-1:0] ctl_q, ctl_d;
  rsu_pkg::rsu_status_t sts_q, sts_d;
  logic [WD_W-1:0] wd_q, wd_d;
  logic dout_q;
  logic cfg_load_q, app_q, user_q;
  logic [31:0] addr_q, addr_d;

  // Control word fields
  logic ctl_anf, ctl_wden, upd_anf;
  logic [23:0] upd_addr;
  logic [`RSU_WD_TIMEOUT_W-1:0] ctl_wdt;

  assign ctl_anf = ctl_q[`RSU_CTL_ANF];
  assign ctl_wden = ctl_q[`RSU_CTL_WDEN];
  assign ctl_wdt = ctl_q[`RSU_CTL_WDT_MSB:`RSU_CTL_WDT_LSB];
  assign upd_anf = upd_q[`RSU_CTL_ANF];
  assign upd_addr = upd_q[`RSU_CTL_ADDR_MSB:`RSU_CTL_ADDR_LSB];

  // Fault and watchdog conditions
  logic loading, load_fail, wd_run, wd_hit, auto_restart;

  assign auto_restart = mode_s;
  assign loading = (state_q == rsu_pkg::RSU_DEV_LOAD_FACT) ||
                   (state_q == rsu_pkg::RSU_DEV_LOAD_APP);
  assign load_fail = loading & (crc_s | exterr_s);
  assign wd_run = (state_q == rsu_pkg::RSU_DEV_APP) & ctl_wden;
  assign wd_hit = wd_run & (wd_q == {ctl_wdt, {WD_GRAN_LOG2{1'b0}}});

  // Cause code for a failed load
  function automatic rsu_pkg::rsu_status_t fail_cause(input logic crc);
    rsu_pkg::rsu_status_t c;
    c = `RSU_STS_RESET;
    if (crc) begin
      c[`RSU_STS_CRC] = 1'b1;
    end else begin
      c[`RSU_STS_EXTERR] = 1'b1;
    end
    return c;
  endfunction : fail_cause

  // Shift register path and application read-only guard
  always_comb begin
    shift_d = shift_q;
    upd_d = upd_q;
    if (sclk_rise) begin
      if (snl_s) begin
        shift_d = {din_s, shift_q[`RSU_SHIFT_W-1:1]};
      end else if (cnu_s) begin
        shift_d = {ctl_q, sts_q};
      end else if (!ctl_anf) begin
        upd_d = shift_q[`RSU_SHIFT_W-1:`RSU_STS_W];
      end
    end
    if (state_d == rsu_pkg::RSU_DEV_LOAD_FACT && state_q != state_d) begin
      upd_d = `RSU_CTL_RESET;
    end
  end

  // Load sequencer
  always_comb begin
    state_d = state_q;
    ctl_d = ctl_q;
    sts_d = sts_q;
    addr_d = addr_q;
    if (!cfgpin_n_s) begin
      sts_d = `RSU_STS_RESET;
      sts_d[`RSU_STS_CFGPIN] = 1'b1;
      state_d = rsu_pkg::RSU_DEV_LOAD_FACT;
    end else begin
      case (state_q)
        rsu_pkg::RSU_DEV_LOAD_FACT, rsu_pkg::RSU_DEV_LOAD_APP: begin
          if (load_fail) begin
            sts_d = fail_cause(crc_s);
            state_d = auto_restart ? rsu_pkg::RSU_DEV_LOAD_FACT :
                                     rsu_pkg::RSU_DEV_HALT;
          end else if (done_s) begin
            state_d = (state_q == rsu_pkg::RSU_DEV_LOAD_APP) ?
                      rsu_pkg::RSU_DEV_APP : rsu_pkg::RSU_DEV_FACTORY;
          end
        end
        rsu_pkg::RSU_DEV_FACTORY: begin
          if (req_fall) begin
            ctl_d = upd_q;
            sts_d = `RSU_STS_RESET;
            sts_d[`RSU_STS_CORE] = 1'b1;
            state_d = upd_anf ? rsu_pkg::RSU_DEV_LOAD_APP :
                                rsu_pkg::RSU_DEV_LOAD_FACT;
          end
        end
        rsu_pkg::RSU_DEV_APP: begin
          if (wd_hit) begin
            sts_d = `RSU_STS_RESET;
            sts_d[`RSU_STS_WDOG] = 1'b1;
            state_d = rsu_pkg::RSU_DEV_LOAD_FACT;
          end else if (req_fall) begin
            sts_d = `RSU_STS_RESET;
            sts_d[`RSU_STS_CORE] = 1'b1;
            state_d = rsu_pkg::RSU_DEV_LOAD_FACT;
          end
        end
        rsu_pkg::RSU_DEV_HALT: begin
          state_d = rsu_pkg::RSU_DEV_HALT;
        end
        default: begin
          state_d = rsu_pkg::RSU_DEV_LOAD_FACT;
        end
      endcase
    end
    if (state_d == rsu_pkg::RSU_DEV_LOAD_FACT) begin
      ctl_d = `RSU_CTL_RESET;
    end
    if (state_d == rsu_pkg::RSU_DEV_LOAD_FACT) begin
      addr_d = {`RSU_FACTORY_ADDR, `RSU_ADDR_LOW_BYTE};
    end else if (state_d == rsu_pkg::RSU_DEV_LOAD_APP) begin
      addr_d = {upd_addr, `RSU_ADDR_LOW_BYTE};
    end
  end

  // Watchdog counter: cleared outside the application, restarted by core
  always_comb begin
    wd_d = '0;
    if (wd_run && !wdr_fall) begin
      wd_d = wd_q + {{(WD_W-1){1'b0}}, 1'b1};
    end
  end

  // Edge history and link output
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_p_q <= 1'b0;
      req_n_p_q <= 1'b1;
      wdr_n_p_q <= 1'b1;
      dout_q <= 1'b0;
    end else begin
      sclk_p_q <= sclk_s;
      req_n_p_q <= req_n_s;
      wdr_n_p_q <= wdr_n_s;
      dout_q <= shift_d[0];
    end
  end

  // Upgrade register set
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= rsu_pkg::RSU_DEV_LOAD_FACT;
      shift_q <= '0;
      upd_q <= `RSU_CTL_RESET;
      ctl_q <= `RSU_CTL_RESET;
      sts_q <= `RSU_STS_RESET;
      wd_q <= '0;
      addr_q <= {`RSU_FACTORY_ADDR, `RSU_ADDR_LOW_BYTE};
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      upd_q <= upd_d;
      ctl_q <= ctl_d;
      sts_q <= sts_d;
      wd_q <= wd_d;
      addr_q <= addr_d;
    end
  end

  // Registered user-side flags
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_load_q <= 1'b1;
      app_q <= 1'b0;
      user_q <= 1'b0;
    end else begin
      cfg_load_q <= (state_d == rsu_pkg::RSU_DEV_LOAD_FACT) ||
                    (state_d == rsu_pkg::RSU_DEV_LOAD_APP);
      app_q <= state_d == rsu_pkg::RSU_DEV_APP;
      user_q <= (state_d == rsu_pkg::RSU_DEV_APP) ||
                (state_d == rsu_pkg::RSU_DEV_FACTORY);
    end
  end

  assign link.upgrade_serial_out = dout_q;
  assign cfg_load_o = cfg_load_q;
  assign cfg_addr_o = addr_q;
  assign app_mode_o = app_q;
  assign user_mode_o = user_q;
  assign status_o = sts_q;
endmodule : rsu_device
`default_nettype wire

// File: rsu_core.sv
// Purpose: core-side controller driving the upgrade signals
// Assumes: software talks over Avalon-MM with waitrequest
// Notes: the shift clock is made here from a divider
`timescale 1ns/100ps
`default_nettype none
`include "rsu_regs.svh"
module rsu_core (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  rsu_if.core link,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);
  localparam int HI_W = `RSU_SHIFT_W - 32;

  logic dout_s;
  rsu_sync #(.W(1), .INIT(1'b0)) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .d_i(link.upgrade_serial_out),
    .q_o(dout_s)
  );

  rsu_pkg::rsu_core_state_e st_q;
  logic wait_q, irq_q;
  logic [31:0] rdata_q;
  logic [`RSU_SHIFT_W-1:0] tx_q, rx_q;
  logic [`RSU_IRQ_W-1:0] ists_q, ien_q, iset;
  logic [7:0] div_q, pcnt_q;
  logic [5:0] bit_q;
  logic op_wr_q, sclk_q, snl_q, cnu_q, din_q, req_n_q, wdr_n_q;

  // Bus decode: access completes when waitrequest is seen low
  logic wr_acc, busy, tick, last_bit, pulse_busy;
  logic wr_cmd, wr_lo, wr_hi, wr_clr, wr_en;
  assign wr_acc = avs_write_i & ~wait_q;
  assign wr_cmd = wr_acc & (avs_address_i == `RSU_REG_CMD);
  assign wr_lo = wr_acc & (avs_address_i == `RSU_REG_DATA_LO);
  assign wr_hi = wr_acc & (avs_address_i == `RSU_REG_DATA_HI);
  assign wr_clr = wr_acc & (avs_address_i == `RSU_REG_IRQ_CLR);
  assign wr_en = wr_acc & (avs_address_i == `RSU_REG_IRQ_EN);
  assign busy = st_q != rsu_pkg::RSU_CORE_IDLE;
  assign pulse_busy = pcnt_q != 8'd0;
  assign tick = div_q == 8'd0;
  assign last_bit = bit_q == 6'(`RSU_SHIFT_W - 1);

  // Read data selection
  logic [31:0] rsel;
  assign rsel = (avs_address_i == `RSU_REG_CMD) ?
                  {30'h0000_0000, pulse_busy, busy} :
                (avs_address_i == `RSU_REG_DATA_LO) ? rx_q[31:0] :
                (avs_address_i == `RSU_REG_DATA_HI) ?
                  {{(32-HI_W){1'b0}}, rx_q[`RSU_SHIFT_W-1:32]} :
                (avs_address_i == `RSU_REG_IRQ_STS) ? {29'h0, ists_q} :
                (avs_address_i == `RSU_REG_IRQ_EN) ? {29'h0, ien_q} :
                32'h0000_0000;

  // Interrupt events from the sequencers
  assign iset[`RSU_IRQ_RD_DONE] = tick & sclk_q & last_bit & ~op_wr_q &
                                  (st_q == rsu_pkg::RSU_CORE_SHIFT);
  assign iset[`RSU_IRQ_WR_DONE] = tick & sclk_q & (st_q == rsu_pkg::RSU_CORE_UPDT);
  assign iset[`RSU_IRQ_PULSE_DONE] = pcnt_q == 8'd1;

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(wait_q & (avs_read_i | avs_write_i));
      rdata_q <= rsel;
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ists_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ists_q <= (ists_q & ~({`RSU_IRQ_W{wr_clr}} & avs_writedata_i[`RSU_IRQ_W-1:0])) | iset;
      if (wr_en) begin
        ien_q <= avs_writedata_i[`RSU_IRQ_W-1:0];
      end
      irq_q <= |(ists_q & ien_q);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pcnt_q <= 8'd0;
      req_n_q <= 1'b1;
      wdr_n_q <= 1'b1;
    end else if (pulse_busy) begin
      pcnt_q <= pcnt_q - 8'd1;
      if (pcnt_q == 8'd1) begin
        req_n_q <= 1'b1;
        wdr_n_q <= 1'b1;
      end
    end else if (wr_cmd && !busy) begin
      if (avs_writedata_i[`RSU_CMD_RECONF] || avs_writedata_i[`RSU_CMD_WDRST]) begin
        pcnt_q <= `RSU_PULSE_CYC;
      end
      req_n_q <= ~avs_writedata_i[`RSU_CMD_RECONF];
      wdr_n_q <= ~avs_writedata_i[`RSU_CMD_WDRST];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= rsu_pkg::RSU_CORE_IDLE;
      div_q <= 8'd0;
      bit_q <= 6'd0;
      tx_q <= '0;
      rx_q <= '0;
      op_wr_q <= 1'b0;
      sclk_q <= 1'b0;
      snl_q <= 1'b1;
      cnu_q <= 1'b0;
      din_q <= 1'b0;
    end else begin
      div_q <= tick ? `RSU_SCLK_HALF - 8'd1 : div_q - 8'd1;
      if (wr_lo && !busy) begin
        tx_q[31:0] <= avs_writedata_i;
      end
      if (wr_hi && !busy) begin
        tx_q[`RSU_SHIFT_W-1:32] <= avs_writedata_i[HI_W-1:0];
      end
      case (st_q)
        rsu_pkg::RSU_CORE_IDLE: begin
          if (wr_cmd && !pulse_busy && avs_writedata_i[`RSU_CMD_READ]) begin
            st_q <= rsu_pkg::RSU_CORE_CAPT;
            op_wr_q <= 1'b0;
            snl_q <= 1'b0;
            cnu_q <= 1'b1;
          end else if (wr_cmd && !pulse_busy && avs_writedata_i[`RSU_CMD_WRITE]) begin
            st_q <= rsu_pkg::RSU_CORE_SHIFT;
            op_wr_q <= 1'b1;
            snl_q <= 1'b1;
            bit_q <= 6'd0;
            din_q <= tx_q[0];
          end
        end
        rsu_pkg::RSU_CORE_CAPT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              st_q <= rsu_pkg::RSU_CORE_SHIFT;
              snl_q <= 1'b1;
              bit_q <= 6'd0;
              din_q <= tx_q[0];
            end
          end
        end
        rsu_pkg::RSU_CORE_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rx_q <= {dout_s, rx_q[`RSU_SHIFT_W-1:1]};
            end else if (last_bit) begin
              st_q <= op_wr_q ? rsu_pkg::RSU_CORE_UPDT : rsu_pkg::RSU_CORE_IDLE;
              snl_q <= ~op_wr_q;
              cnu_q <= 1'b0;
            end else begin
              bit_q <= bit_q + 6'd1;
              din_q <= tx_q[bit_q + 6'd1];
            end
          end
        end
        rsu_pkg::RSU_CORE_UPDT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              st_q <= rsu_pkg::RSU_CORE_IDLE;
              snl_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= rsu_pkg::RSU_CORE_IDLE;
        end
      endcase
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign link.upgrade_shift_clock = sclk_q;
  assign link.shift_not_load_select = snl_q;
  assign link.capture_not_update_select = cnu_q;
  assign link.upgrade_serial_in = din_q;
  assign link.core_reconfig_request_n = req_n_q;
  assign link.watchdog_restart_n = wdr_n_q;
endmodule : rsu_core
`default_nettype wire

// File: rsu_link_sva.sv
// Purpose: protocol checks on the link between core logic and upgrade circuitry
// Assumes: one clock, reset active low and asynchronous
// Notes: counts follow the 16-cycle pulses and the 8-cycle half period
`timescale 1ns/100ps
`default_nettype none
module rsu_link_sva (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic upgrade_serial_in,
  input wire logic upgrade_serial_out,
  input wire logic shift_not_load_select,
  input wire logic capture_not_update_select,
  input wire logic upgrade_shift_clock,
  input wire logic core_reconfig_request_n,
  input wire logic watchdog_restart_n
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Pulse lengths, clock halves and hold of link levels
  a_req_pulse_len: assert property (
    $fell(core_reconfig_request_n) |-> ##15 !core_reconfig_request_n ##1 core_reconfig_request_n)
    else $error("reconfigure request pulse length wrong");
  a_wd_pulse_len: assert property (
    $fell(watchdog_restart_n) |-> ##15 !watchdog_restart_n ##1 watchdog_restart_n)
    else $error("watchdog restart pulse length wrong");
  a_clk_high_half: assert property (
    $rose(upgrade_shift_clock) |-> upgrade_shift_clock [*8] ##1 !upgrade_shift_clock)
    else $error("shift clock high phase wrong");
  a_clk_low_half: assert property (
    $fell(upgrade_shift_clock) |-> (!upgrade_shift_clock) [*8])
    else $error("shift clock low phase too short");
  a_din_held: assert property (
    $rose(upgrade_shift_clock) |=> ($stable(upgrade_serial_in)) [*7])
    else $error("serial data moved while shift clock high");
  a_sel_held: assert property (
    $rose(upgrade_shift_clock) |=>
      ($stable(shift_not_load_select) && $stable(capture_not_update_select)) [*7])
    else $error("selects moved while shift clock high");
  a_pulse_no_shift: assert property (
    !core_reconfig_request_n |-> !upgrade_shift_clock && watchdog_restart_n)
    else $error("reconfigure pulse overlaps other link activity");
  a_dout_settled: assert property (
    $fell(upgrade_shift_clock) |=> ($stable(upgrade_serial_out)) [*6])
    else $error("serial out moved in shift clock low phase");

  // Main scenarios seen on the link
  c_reconf: cover property ($fell(core_reconfig_request_n));
  c_wd: cover property ($fell(watchdog_restart_n));
  c_capture: cover property ($rose(upgrade_shift_clock) && !shift_not_load_select
    && capture_not_update_select);
  c_update: cover property ($rose(upgrade_shift_clock) && !shift_not_load_select
    && !capture_not_update_select);
endmodule : rsu_link_sva
`default_nettype wire

// File: remote_image_upgrade_control_tb_top.sv
// Purpose: both ends of the upgrade link driven from the core's Avalon side
// Assumes: watchdog granularity shortened to 2^3 cycles
// Notes: load completion and faults are played on the device's load pins
`timescale 1ns/100ps
`default_nettype none
`include "rsu_regs.svh"
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (x), (y)); end end
module remote_image_upgrade_control_tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic remote = 1'b1, done = 1'b0, crc = 1'b0, exterr = 1'b0, pin_n = 1'b1;
  logic load, app, user, rd = 1'b0, wr = 1'b0, wq, irq;
  logic [2:0] a = 3'h0;
  logic [4:0] sts;
  logic [31:0] addr, rdat, r, wd = 32'h0;
  logic [42:0] rx;
  int error_cnt = 0;
  int comparisons = 0;
  rsu_if link ();
  // Clock
  always #2.5 ref_clk_i = ~ref_clk_i;
  // Both ends and the link checker
  rsu_device #(.WD_GRAN_LOG2(3)) rsu_device_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .link(link.dev), .remote_mode_i(remote), .cfg_done_i(done), .cfg_crc_error_i(crc),
    .ext_status_error_i(exterr), .ext_config_n_i(pin_n), .cfg_load_o(load),
    .cfg_addr_o(addr), .app_mode_o(app), .user_mode_o(user), .status_o(sts));
  rsu_core rsu_core_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link.core),
    .avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .irq_o(irq));
  rsu_link_sva rsu_link_sva_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .upgrade_serial_in(link.upgrade_serial_in), .upgrade_serial_out(link.upgrade_serial_out),
    .shift_not_load_select(link.shift_not_load_select),
    .capture_not_update_select(link.capture_not_update_select),
    .upgrade_shift_clock(link.upgrade_shift_clock),
    .core_reconfig_request_n(link.core_reconfig_request_n),
    .watchdog_restart_n(link.watchdog_restart_n));

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    a <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (n == 20) error_cnt++;
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // Issue a command and poll its done bit
  task automatic cmd(input logic [3:0] c, input int b);
    int n;
    n = 0;
    bus(1'b1, `RSU_REG_IRQ_CLR, 32'h0000_0007);
    bus(1'b1, `RSU_REG_CMD, {28'h000_0000, c});
    bus(1'b0, `RSU_REG_CMD, 32'h0000_0000);
    `CHK(|r[1:0], 1'b1)
    do begin
      bus(1'b0, `RSU_REG_IRQ_STS, 32'h0000_0000);
      n++;
    end while (r[b] !== 1'b1 && n < 600);
    `CHK(r[b], 1'b1)
  endtask : cmd

  function automatic logic [42:0] mk(logic f, logic [23:0] ad, logic e, logic [11:0] t);
    return {t, e, ad, f, 5'h00};
  endfunction : mk

  // Capture and read back the whole shift word
  task automatic grab();
    logic [31:0] lo;
    cmd(4'h1, `RSU_IRQ_RD_DONE);
    bus(1'b0, `RSU_REG_DATA_LO, 32'h0000_0000);
    lo = r;
    bus(1'b0, `RSU_REG_DATA_HI, 32'h0000_0000);
    rx = {r[10:0], lo};
  endtask : grab

  // Write the update word, then request reconfiguration
  task automatic put(input logic [42:0] w);
    bus(1'b1, `RSU_REG_DATA_LO, w[31:0]);
    bus(1'b1, `RSU_REG_DATA_HI, {21'h00_0000, w[42:32]});
    cmd(4'h2, `RSU_IRQ_WR_DONE);
    cmd(4'h4, `RSU_IRQ_PULSE_DONE);
  endtask : put

  // Report a finished image load
  task automatic boot();
    repeat (8) @(posedge ref_clk_i);
    done <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    done <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask : boot

  task automatic t_boot();
    `CHK(load, 1'b1)
    `CHK(addr, 32'h0000_0000)
    boot();
    `CHK({user, app}, 2'b10)
  endtask : t_boot

  task automatic t_irq();
    bus(1'b1, `RSU_REG_IRQ_EN, 32'h0000_0000);
    grab();
    `CHK(irq, 1'b0)
    `CHK(rx, 43'h000_0000_0000)
    bus(1'b1, `RSU_REG_IRQ_EN, 32'h0000_0007);
    bus(1'b0, `RSU_REG_IRQ_EN, 32'h0000_0000);
    `CHK(r, 32'h0000_0007)
    `CHK(irq, 1'b1)
    bus(1'b1, `RSU_REG_IRQ_CLR, 32'h0000_0007);
    bus(1'b0, 3'h7, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    `CHK(irq, 1'b0)
  endtask : t_irq

  task automatic t_app();
    put(mk(1'b1, 24'h12_3456, 1'b0, 12'h000));
    `CHK(addr, 32'h1234_5600)
    `CHK(sts, 5'h04)
    boot();
    `CHK(app, 1'b1)
    grab();
    `CHK(rx, mk(1'b1, 24'h12_3456, 1'b0, 12'h000) | 43'h004)
    cmd(4'h4, `RSU_IRQ_PULSE_DONE);
    `CHK({load, addr, sts}, 38'h20_0000_0004)
  endtask : t_app

  task automatic t_pin();
    pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    pin_n <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    `CHK({load, addr}, 33'h1_0000_0000)
    `CHK(sts, 5'h08)
    boot();
    `CHK(app, 1'b0)
  endtask : t_pin

  // CRC error, then external error, during an application load
  task automatic t_fail();
    for (int i = 0; i < 2; i++) begin
      put(mk(1'b1, 24'h00_0200, 1'b0, 12'h000));
      crc <= (i == 0);
      exterr <= (i == 1);
      repeat (8) @(posedge ref_clk_i);
      crc <= 1'b0;
      exterr <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      `CHK({load, addr}, 33'h1_0000_0000)
      `CHK(sts, (i == 0) ? 5'h01 : 5'h02)
      boot();
      `CHK(app, 1'b0)
      grab();
      `CHK(rx[42:5], 38'h00_0000_0000)
    end
    remote <= 1'b0;
    put(mk(1'b1, 24'h00_0200, 1'b0, 12'h000));
    crc <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    crc <= 1'b0;
    `CHK({load, user, sts}, 7'h01)
    t_pin();
    remote <= 1'b1;
  endtask : t_fail

  // Watchdog kept alive three times, then left to expire after 64 cycles
  task automatic t_wdog();
    int n;
    n = 0;
    put(mk(1'b1, 24'h00_0400, 1'b1, 12'h008));
    boot();
    repeat (3) begin
      cmd(4'h8, `RSU_IRQ_PULSE_DONE);
      `CHK(app, 1'b1)
    end
    while (load !== 1'b1 && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK({load, addr}, 33'h1_0000_0000)
    `CHK(sts, 5'h10)
    boot();
  endtask : t_wdog

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_boot();
    t_irq();
    t_app();
    t_pin();
    t_fail();
    t_wdog();
    close_out();
  end

  // Hang guard
  initial begin
    #150000;
    error_cnt++;
    close_out();
  end
endmodule : remote_image_upgrade_control_tb_top
`default_nettype wire
